/* pkg/dbgsc_cfg.svh */
// constants for the debug status and control register block
`ifndef DBGSC_CFG_SVH
`define DBGSC_CFG_SVH
// ==========================================================
// field positions
`define DBGSC_BIT_PERMIT     7
`define DBGSC_BIT_ACTIVE     6
`define DBGSC_BIT_BKPT_EN    5
`define DBGSC_BIT_FORCE_TAG  4
`define DBGSC_BIT_CLK_SEL    3
`define DBGSC_BIT_PERMIT_POS 7
// ==========================================================
// reset values
`define DBGSC_RESET_CTRL     8'h00
// ==========================================================
// serial timing and instruction queue depth
`define DBGSC_CYCLES_PER_BIT 16
`define DBGSC_QUEUE_DEPTH    2
`endif

/* pkg/dbgsc_pkg.sv */
// types for the debug status and control register block
package dbgsc_pkg;
	// ==========================================================
	// serial command kinds seen by the register
	typedef enum logic [1:0] {
		DBGSC_CMD_NONE,
		DBGSC_CMD_READ_STATUS,
		DBGSC_CMD_WRITE_CONTROL
	} dbgsc_cmd_t;
	// ==========================================================
	// run state of the processor
	typedef enum logic [1:0] {
		DBGSC_RUN,
		DBGSC_HALT_PENDING,
		DBGSC_HALTED
	} dbgsc_mode_t;
endpackage : dbgsc_pkg

/* src/dbgsc_tag_queue.sv */
// instruction queue tag tracker for tagged breakpoints
`timescale 1ns/100ps
module dbgsc_tag_queue #(
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// queue movement
	input  wire logic i_fetch,
	input  wire logic i_tag,
	input  wire logic i_advance,
	input  wire logic i_flush,
	// tag at the end of the queue
	output logic      o_tag_at_end
);
	// refuse a queue with no slots
	if (DEPTH < 1) begin : g_bad_depth
		$error("depth below one");
	end

	typedef struct packed {
		logic [DEPTH-1:0] tags;
		logic             tag_at_end;
	} dbgsc_tq_state_t;

	dbgsc_tq_state_t state;
	dbgsc_tq_state_t next_state;

	// a fetch loads its tag into the back slot; each advance moves the slots
	// one step on, and a tag leaving slot 0 gives a one-cycle pulse
	always_comb begin
		next_state            = state;
		next_state.tag_at_end = 1'b0;
		if (i_flush) begin
			next_state.tags = '0;
		end else begin
			if (i_advance) begin
				next_state.tag_at_end = state.tags[0];
				next_state.tags       = state.tags >> 1;
			end
			if (i_fetch) begin
				next_state.tags[DEPTH-1] = i_tag;
			end
		end
	end

	// register the state
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_tag_at_end = state.tag_at_end;
endmodule : dbgsc_tag_queue

/* src/dbgsc_ctrl.sv */
// debug status and control register with breakpoint and halt logic
// ==========================================================
// Summary of operation
// - Register reached only through serial read-status and write-control commands.
// - Bit 7 permits background mode; once set stays until normal reset.
// - Without permit, background entry refused; non-intrusive commands still run.
// - Bit 6 read-only: one while halted awaiting commands, zero while running.
// - Bit 5 enables breakpoint; when clear, select bit and match ignored.
// - Bit 4 set: address match forces halt at next instruction boundary.
// - Bit 4 clear: match tags opcode; halt when tag reaches queue end.
// - Bit 3 picks comm clock: zero alternate clock (default), one bus clock.
// - Serial data most significant bit first, sixteen comm clocks per bit.
`timescale 1ns/100ps
`include "dbgsc_cfg.svh"
module dbgsc_ctrl
	import dbgsc_pkg::*;
#(
	parameter int ADDR_W      = 16,
	parameter int QUEUE_DEPTH = `DBGSC_QUEUE_DEPTH
) (
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	// serial command decoder side
	input  wire logic              i_cmd_valid,
	input  wire dbgsc_cmd_t        i_cmd,
	input  wire logic [7:0]        i_cmd_wdata,
	input  wire logic              i_go,
	output logic [7:0]             o_status,
	output logic                   o_status_valid,
	// breakpoint address
	input  wire logic [ADDR_W-1:0] i_bkpt_addr,
	// processor side
	input  wire logic [ADDR_W-1:0] i_cpu_addr,
	input  wire logic              i_cpu_addr_valid,
	input  wire logic              i_cpu_fetch,
	input  wire logic              i_queue_advance,
	input  wire logic              i_instr_boundary,
	input  wire logic              i_bgnd_request,
	// controls out
	output logic                   o_halt,
	output logic                   o_comm_clock_select
);
	// ==========================================================
	// parameter checks, refused at elaboration
	if (ADDR_W < 1) begin : g_bad_addr_w
		$error("address width below one");
	end
	if (QUEUE_DEPTH < 1) begin : g_bad_queue_depth
		$error("queue depth below one");
	end

	// ==========================================================
	// reset release
	logic [1:0] rst_sync;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	wire logic rst_n;
	assign rst_n = rst_sync[1];

	// ==========================================================
	// state
	typedef struct packed {
		logic        background_permit;
		logic        breakpoint_enable;
		logic        force_tag_select;
		logic        comm_clock_select;
		dbgsc_mode_t mode;
		logic        force_pending;     // forced match waiting for a boundary
		logic        halted;            // flop copy of the halted mode
		logic [7:0]  status;
		logic        status_valid;
	} dbgsc_state_t;

	dbgsc_state_t state;
	dbgsc_state_t next_state;

	logic tag_at_end;

	// compose the readable register image
	function automatic logic [7:0] dbgsc_image(input dbgsc_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[`DBGSC_BIT_PERMIT_POS] = s.background_permit;
		v[`DBGSC_BIT_ACTIVE]     = (s.mode == DBGSC_HALTED);
		v[`DBGSC_BIT_BKPT_EN]    = s.breakpoint_enable;
		v[`DBGSC_BIT_FORCE_TAG]  = s.force_tag_select;
		v[`DBGSC_BIT_CLK_SEL]    = s.comm_clock_select;
		return v;
	endfunction : dbgsc_image

	// decode one command kind from the serial decoder strobe
	function automatic logic dbgsc_is_cmd(input logic valid, input dbgsc_cmd_t cmd,
		input dbgsc_cmd_t kind);
		return valid && (cmd == kind);
	endfunction : dbgsc_is_cmd

	// ==========================================================
	// command strobes
	wire logic cmd_write;
	wire logic cmd_read;
	assign cmd_write = dbgsc_is_cmd(i_cmd_valid, i_cmd, DBGSC_CMD_WRITE_CONTROL);
	assign cmd_read  = dbgsc_is_cmd(i_cmd_valid, i_cmd, DBGSC_CMD_READ_STATUS);

	wire logic match;
	assign match = state.breakpoint_enable && i_cpu_addr_valid
		&& (i_cpu_addr == i_bkpt_addr);

	// tag tracker for the instruction queue
	dbgsc_tag_queue #(
		.DEPTH (QUEUE_DEPTH)
	) u_tag_queue (
		.i_mclk       (i_mclk),
		.i_rst_n      (rst_n),
		.i_fetch      (i_cpu_fetch),
		.i_tag        (match && !state.force_tag_select),
		.i_advance    (i_queue_advance),
		.i_flush      (state.mode != DBGSC_RUN),
		.o_tag_at_end (tag_at_end)
	);

	// command handling, breakpoint and halt sequencing
	always_comb begin
		next_state = state;
		next_state.status_valid = 1'b0;
		if (cmd_write) begin
			next_state.background_permit = state.background_permit
				| i_cmd_wdata[`DBGSC_BIT_PERMIT_POS];
			next_state.breakpoint_enable = i_cmd_wdata[`DBGSC_BIT_BKPT_EN];
			next_state.force_tag_select  = i_cmd_wdata[`DBGSC_BIT_FORCE_TAG];
			next_state.comm_clock_select = i_cmd_wdata[`DBGSC_BIT_CLK_SEL];
		end
		if (cmd_read) begin
			next_state.status       = dbgsc_image(state);
			next_state.status_valid = 1'b1;
		end
		// forced match waits for the instruction boundary
		if (match && state.force_tag_select && state.mode == DBGSC_RUN) begin
			next_state.force_pending = 1'b1;
		end
		case (state.mode)
			DBGSC_RUN: begin
				if (state.background_permit && (i_bgnd_request
					|| (state.breakpoint_enable && tag_at_end))) begin
					next_state.mode = DBGSC_HALTED;
				end else if (state.background_permit
					&& (state.force_pending || next_state.force_pending)) begin
					next_state.mode = DBGSC_HALT_PENDING;
				end
				if (!state.background_permit) begin
					next_state.force_pending = 1'b0;
				end
			end
			DBGSC_HALT_PENDING: begin
				if (i_instr_boundary) begin
					next_state.mode          = DBGSC_HALTED;
					next_state.force_pending = 1'b0;
				end
			end
			DBGSC_HALTED: begin
				next_state.force_pending = 1'b0;
				if (i_go) begin
					next_state.mode = DBGSC_RUN;
				end
			end
			default: begin
				next_state.mode = DBGSC_RUN;
			end
		endcase
		// halted flag follows the next mode so o_halt is a plain flop
		next_state.halted = (next_state.mode == DBGSC_HALTED);
	end

	// register the state; normal reset clears everything
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flip-flops
	assign o_status            = state.status;
	assign o_status_valid      = state.status_valid;
	assign o_halt              = state.halted;
	assign o_comm_clock_select = state.comm_clock_select;
endmodule : dbgsc_ctrl

/* verification/dbgsc_ctrl_chk.sv */
// assertions on the debug status and control register ports
`timescale 1ns/100ps
module dbgsc_ctrl_chk
	import dbgsc_pkg::*;
#(parameter int ADDR_W = 16) (
	// watched ports
	input wire logic i_mclk, i_rst_n, i_cmd_valid, i_go, i_instr_boundary, i_bgnd_request,
	input wire logic i_cpu_addr_valid, o_status_valid, o_halt, o_comm_clock_select,
	input wire dbgsc_cmd_t i_cmd,
	input wire logic [7:0] i_cmd_wdata, o_status,
	input wire logic [ADDR_W-1:0] i_bkpt_addr, i_cpu_addr
);
	logic perm, en, frc, seen;
	wire wr = i_cmd_valid && i_cmd == DBGSC_CMD_WRITE_CONTROL;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// control bits as last written, and any cause for a halt so far
	always_ff @(posedge i_mclk or negedge i_rst_n)
		if (!i_rst_n) {perm, en, frc, seen} <= 4'h0;
		else begin
			if (wr) {perm, en, frc} <= {perm | i_cmd_wdata[7], i_cmd_wdata[5:4]};
			seen <= seen | en | i_bgnd_request;
		end
	sequence s_fm;
		i_cpu_addr_valid && i_cpu_addr == i_bkpt_addr && perm && en && frc && !o_halt;
	endsequence
	sequence s_bnd;
		s_fm ##[1:4] (i_instr_boundary && !i_go);
	endsequence
	property p_rd; i_cmd_valid && i_cmd == DBGSC_CMD_READ_STATUS |=> o_status_valid; endproperty
	property p_rsv; o_status_valid |-> o_status[2:0] == 3'h0; endproperty
	property p_act; o_status_valid && $stable(o_halt) |-> o_status[6] == o_halt; endproperty
	property p_perm; o_status_valid |-> o_status[7] == perm; endproperty
	property p_ref; $rose(o_halt) |-> perm; endproperty
	property p_bk; $rose(o_halt) |-> seen; endproperty
	property p_clk; wr |=> o_comm_clock_select == $past(i_cmd_wdata[3]); endproperty
	property p_frc; s_bnd |=> o_halt; endproperty
	a_rd: assert property (p_rd) else $error("no status reply");
	a_rsv: assert property (p_rsv) else $error("low bits set");
	a_act: assert property (p_act) else $error("active bit wrong");
	a_perm: assert property (p_perm) else $error("permit bit wrong");
	a_ref: assert property (p_ref) else $error("halt without permit");
	a_bk: assert property (p_bk) else $error("halt without cause");
	a_clk: assert property (p_clk) else $error("clock select wrong");
	a_frc: assert property (p_frc) else $error("forced halt missing");
endmodule : dbgsc_ctrl_chk
bind dbgsc_ctrl dbgsc_ctrl_chk #(.ADDR_W(ADDR_W)) dbgsc_ctrl_chk_i (.i_mclk, .i_rst_n,
	.i_cmd_valid, .i_go, .i_instr_boundary, .i_bgnd_request, .i_cpu_addr_valid,
	.o_status_valid, .o_halt, .o_comm_clock_select, .i_cmd, .i_cmd_wdata, .o_status,
	.i_bkpt_addr, .i_cpu_addr);

/* verification/dbgsc_host.sv */
// debug host model issuing register commands
`timescale 1ns/100ps
module dbgsc_host
	import dbgsc_pkg::*;
(
	// clock and command
	input  wire logic  i_mclk,
	output dbgsc_cmd_t o_cmd,
	output logic       o_cmd_valid,
	output logic [7:0] o_cmd_wdata
);
	// one command for one cycle, then idle with scrambled data
	task automatic send(input dbgsc_cmd_t c, input logic [7:0] d);
		@(posedge i_mclk) o_cmd <= c;
		o_cmd_valid <= 1'h1;
		o_cmd_wdata <= d;
		@(posedge i_mclk) o_cmd <= DBGSC_CMD_NONE;
		o_cmd_valid <= 1'h0;
		o_cmd_wdata <= ~d;
	endtask : send
	// idle before the first command
	initial begin
		o_cmd = DBGSC_CMD_NONE;
		o_cmd_valid = 1'h0;
		o_cmd_wdata = 8'h00;
	end
endmodule : dbgsc_host

/* verification/testbench.sv */
// self-checking bench for the debug status and control register
`timescale 1ns/100ps
module testbench;
	import dbgsc_pkg::*;
	logic i_mclk = 1'h0, i_rst_n = 1'h0, i_go = 1'h0, i_cpu_fetch = 1'h0, perm = 1'h0;
	logic i_cpu_addr_valid = 1'h0, i_queue_advance = 1'h0, i_instr_boundary = 1'h0;
	logic i_bgnd_request = 1'h0, i_cmd_valid, o_status_valid, o_halt, o_comm_clock_select;
	logic [15:0] i_bkpt_addr = 16'h0000, i_cpu_addr = 16'h0000;
	logic [31:0] seed = 32'h000168A9;
	logic [7:0] i_cmd_wdata, o_status, w;
	dbgsc_cmd_t i_cmd;
	int fail_count = 0, samples_checked = 0;
	// 25 ns clock
	always #12.5 i_mclk = ~i_mclk;
	dbgsc_host dbgsc_host_i (.i_mclk, .o_cmd(i_cmd), .o_cmd_valid(i_cmd_valid),
		.o_cmd_wdata(i_cmd_wdata));
	dbgsc_ctrl dbgsc_ctrl_i (.i_mclk, .i_rst_n, .i_cmd_valid, .i_cmd, .i_cmd_wdata, .i_go,
		.o_status, .o_status_valid, .i_bkpt_addr, .i_cpu_addr, .i_cpu_addr_valid, .i_cpu_fetch,
		.i_queue_advance, .i_instr_boundary, .i_bgnd_request, .o_halt, .o_comm_clock_select);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] image(input logic p, h, input logic [7:0] d);
		return {p, h, d[5:3], 3'h0};
	endfunction : image
	task automatic check(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test
	task automatic rd(input logic [7:0] e);
		dbgsc_host_i.send(DBGSC_CMD_READ_STATUS, 8'h00);
		#1 check(o_status, e);
		check({7'h00, o_status_valid}, 8'h01);
	endtask : rd
	// pulses of go, queue advance, boundary
	task automatic ev(input logic [2:0] e);
		@(posedge i_mclk) {i_go, i_queue_advance, i_instr_boundary} <= e;
		@(posedge i_mclk) {i_go, i_queue_advance, i_instr_boundary} <= 3'h0;
	endtask : ev
	task automatic hit(input logic f);
		@(posedge i_mclk) {i_cpu_addr, i_cpu_addr_valid, i_cpu_fetch} <= {i_bkpt_addr, 1'h1, f};
		@(posedge i_mclk) {i_cpu_addr, i_cpu_addr_valid, i_cpu_fetch} <= {~i_bkpt_addr, 2'h0};
	endtask : hit
	task automatic halt_is(input logic v);
		#1;
		for (int n = 0; o_halt !== v; n++) begin
			if (n == 8) begin
				fail_count++;
				$display("Error at %0t: halt wait ran out", $time);
				end_of_test();
			end
			@(posedge i_mclk) #1;
		end
	endtask : halt_is
	initial begin
		repeat (16) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		repeat (3) @(posedge i_mclk);
		rd(8'h00);
		@(posedge i_mclk) i_bgnd_request <= 1'h1;
		rd(8'h00);
		@(posedge i_mclk) i_bgnd_request <= 1'h0;
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			w = k == 0 ? 8'h47 : k == 1 ? 8'hFF : k == 2 ? 8'h00 : seed[7:0];
			perm = perm | w[7];
			@(posedge i_mclk) i_bkpt_addr <= seed[31:16];
			dbgsc_host_i.send(DBGSC_CMD_WRITE_CONTROL, w);
			rd(image(perm, 1'h0, w));
			check({7'h00, o_comm_clock_select}, {7'h00, w[3]});
		end
		dbgsc_host_i.send(DBGSC_CMD_WRITE_CONTROL, 8'hB0);
		hit(1'h0);
		ev(3'h1);
		halt_is(1'h1);
		rd(image(1'h1, 1'h1, 8'hB0));
		ev(3'h4);
		halt_is(1'h0);
		dbgsc_host_i.send(DBGSC_CMD_WRITE_CONTROL, 8'h90);
		hit(1'h1);
		ev(3'h3);
		ev(3'h3);
		repeat (2) @(posedge i_mclk);
		#1 check({7'h00, o_halt}, 8'h00);
		dbgsc_host_i.send(DBGSC_CMD_WRITE_CONTROL, 8'hA0);
		hit(1'h1);
		ev(3'h2);
		repeat (2) @(posedge i_mclk);
		#1 check({7'h00, o_halt}, 8'h00);
		ev(3'h2);
		halt_is(1'h1);
		ev(3'h4);
		halt_is(1'h0);
		// mid-run normal reset clears the sticky permit and the clock select
		dbgsc_host_i.send(DBGSC_CMD_WRITE_CONTROL, 8'h08);
		@(posedge i_mclk) i_rst_n <= 1'h0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'h1;
		repeat (3) @(posedge i_mclk);
		rd(8'h00);
		check({7'h00, o_comm_clock_select}, 8'h00);
		end_of_test();
	end
endmodule : testbench
